// ---- core/ipm_core.sv ----
// Interrupt pending word, mask word, routing and index vectors for 32 request sources
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - A read-only 32-bit pending word shows 1 for each source with a request pending and 0 otherwise.
// - Bits 31 to 24 are external fault, system serial, PWM units 0 to 3, fault multiplexer and converter.
// - Bits 23 to 16 are constant power/clock, wide compare 0, capture 0, compare 1, capture 1, overflow, timers 0 and 1.
// - Bits 15 to 8 are timers 2 and 3, front ends 2 to 0, comparator/serial group, PMBus and second transmitter.
// - Bits 7 to 0 are second receiver, first transmitter, first receiver, error, watchdog half and max, pin, brownout.
// - The pending word has no defined value after reset and only follows the request lines.
// - A 32-bit read/write mask word uses the same bit layout and clears to zero at reset.
// - A per-source routing bit picks the normal line when zero, the default, and the fast line when one.
// - Each index register shows zero when no unmasked source routed to its line is pending, otherwise N for channel N-1, highest channel first.
module ipm_core (
  input wire logic mclk, // System clock, 50 MHz
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic [ipm_pkg::ADDR_W-1:0] bus_addr, // Register byte address
  input wire logic [ipm_pkg::DATA_W-1:0] bus_wdata, // Write data
  input wire logic bus_wr, // Write strobe, one cycle
  input wire logic bus_rd, // Read strobe, one cycle
  output logic [ipm_pkg::DATA_W-1:0] bus_rdata, // Read data, cycle after strobe
  input wire logic external_fault_request, // Pin, external fault
  input wire logic system_serial_request, // System serial port
  input wire logic pwm_unit0_request, // PWM unit 0
  input wire logic pwm_unit1_request, // PWM unit 1
  input wire logic pwm_unit2_request, // PWM unit 2
  input wire logic pwm_unit3_request, // PWM unit 3
  input wire logic fault_mux_request, // Fault multiplexer
  input wire logic adc_request, // Analogue-to-digital converter
  input wire logic constant_power_rtc_request, // Constant power / real-time clock
  input wire logic wide_timer_compare0_request, // 24-bit compare 0
  input wire logic wide_timer_capture0_request, // 24-bit capture 0
  input wire logic wide_timer_compare1_request, // 24-bit compare 1
  input wire logic capture1_deadtime_request, // 24-bit capture 1 / dead time
  input wire logic wide_timer_overflow_request, // 24-bit overflow
  input wire logic narrow_timer0_request, // 16-bit timer 0
  input wire logic narrow_timer1_request, // 16-bit timer 1
  input wire logic narrow_timer2_request, // 16-bit timer 2
  input wire logic narrow_timer3_request, // 16-bit timer 3
  input wire logic front_end2_request, // Front end 2
  input wire logic front_end1_request, // Front end 1
  input wire logic front_end0_request, // Front end 0
  input wire logic comparator_serial_group_request, // Comparator / I2C / SPI group
  input wire logic pmbus_request, // PMBus port
  input wire logic uart1_tx_request, // Second UART transmitter
  input wire logic uart1_rx_request, // Second UART receiver
  input wire logic uart0_tx_request, // First UART transmitter
  input wire logic uart0_rx_request, // First UART receiver
  input wire logic uart_error_request, // Combined UART error
  input wire logic watchdog_half_count_request, // Watchdog half count
  input wire logic watchdog_max_count_request, // Watchdog maximum count
  input wire logic external_pin_request, // Pin, external interrupt
  input wire logic brownout_request, // Brownout detector, asynchronous
  output logic normal_irq, // Normal interrupt line, level
  output logic fast_irq, // Fast interrupt line, level
  output logic event_irq, // Sticky event interrupt, level
  output logic [ipm_pkg::IDX_W-1:0] normal_line_index_vector, // Top normal source index
  output logic [ipm_pkg::IDX_W-1:0] fast_line_index_vector // Top fast source index
);
  import ipm_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [DATA_W-1:0] pending;
    logic [DATA_W-1:0] mask;
    logic [DATA_W-1:0] route;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] rdata;
    logic [IDX_W-1:0] normal_idx;
    logic [IDX_W-1:0] fast_idx;
    logic normal_line;
    logic fast_line;
    logic event_line;
  } ipm_state_type;

  ipm_state_type state_reg;
  ipm_state_type state_next;

  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_sync;
  logic [SRC_N-1:0] req_vec;
  logic [SRC_N-1:0] rise_vec;
  logic [SRC_N-1:0] status_clear;
  logic [SRC_N-1:0] normal_vec;
  logic [SRC_N-1:0] fast_vec;
  logic [SRC_N-1:0] pending_new;
  logic [SRC_N-1:0] mask_new;
  logic [SRC_N-1:0] route_new;
  logic [SRC_N-1:0] status_new;

  // ****************************************************************
  // Pin-driven requests
  // ****************************************************************
  // Fault, pin and brownout come from outside the clock domain
  assign pin_raw = {external_fault_request, external_pin_request, brownout_request};

  ipm_sync u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_in(pin_raw),
    .pin_sync(pin_sync)
  );

  // ****************************************************************
  // Request vector assembly
  // ****************************************************************
  // Upper byte of sources
  always_comb begin
    req_vec = '0;
    req_vec[BIT_EXT_FAULT] = pin_sync[2];
    req_vec[BIT_SYS_SERIAL] = system_serial_request;
    req_vec[BIT_PWM0] = pwm_unit0_request;
    req_vec[BIT_PWM1] = pwm_unit1_request;
    req_vec[BIT_PWM2] = pwm_unit2_request;
    req_vec[BIT_PWM3] = pwm_unit3_request;
    req_vec[BIT_FAULT_MUX] = fault_mux_request;
    req_vec[BIT_ADC] = adc_request;
    // Second byte: power, clock and 24/16-bit timers
    req_vec[BIT_CPOWER_RTC] = constant_power_rtc_request;
    req_vec[BIT_WCMP0] = wide_timer_compare0_request;
    req_vec[BIT_WCAP0] = wide_timer_capture0_request;
    req_vec[BIT_WCMP1] = wide_timer_compare1_request;
    req_vec[BIT_WCAP1_DT] = capture1_deadtime_request;
    req_vec[BIT_WOVF] = wide_timer_overflow_request;
    req_vec[BIT_NT0] = narrow_timer0_request;
    req_vec[BIT_NT1] = narrow_timer1_request;
    // Third byte: timers, front ends and serial ports
    req_vec[BIT_NT2] = narrow_timer2_request;
    req_vec[BIT_NT3] = narrow_timer3_request;
    req_vec[BIT_FE2] = front_end2_request;
    req_vec[BIT_FE1] = front_end1_request;
    req_vec[BIT_FE0] = front_end0_request;
    req_vec[BIT_CMP_SERIAL] = comparator_serial_group_request;
    req_vec[BIT_PMBUS] = pmbus_request;
    req_vec[BIT_U1_TX] = uart1_tx_request;
    // Low byte: UARTs, watchdog, pin and brownout
    req_vec[BIT_U1_RX] = uart1_rx_request;
    req_vec[BIT_U0_TX] = uart0_tx_request;
    req_vec[BIT_U0_RX] = uart0_rx_request;
    req_vec[BIT_U_ERR] = uart_error_request;
    req_vec[BIT_WD_HALF] = watchdog_half_count_request;
    req_vec[BIT_WD_MAX] = watchdog_max_count_request;
    req_vec[BIT_EXT_PIN] = pin_sync[1];
    req_vec[BIT_BROWNOUT] = pin_sync[0];
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Mask word: software-owned, feeds every gate below
  always_comb begin
    mask_new = state_reg.mask;
    if (bus_wr && (bus_addr == MASK_WORD_ADDR)) begin
      mask_new = bus_wdata;
    end
  end

  // Route select: zero sends a source to the normal line
  always_comb begin
    route_new = state_reg.route;
    if (bus_wr && (bus_addr == ROUTE_SELECT_ADDR)) begin
      route_new = bus_wdata;
    end
  end

  // Writes to the pending word or the index registers are ignored, they are read-only
  assign status_clear = (bus_wr && (bus_addr == EVENT_STATUS_ADDR)) ? bus_wdata : '0;

  // ****************************************************************
  // Pending word and sticky events
  // ****************************************************************
  // Pending follows the live request level one cycle late; no latch, so no stale state
  assign pending_new = req_vec;

  // A new request is a rising level on the pending word
  assign rise_vec = req_vec & ~state_reg.pending;

  // Set wins over a write-one clear in the same cycle, so no event is lost
  assign status_new = (state_reg.status & ~status_clear) | rise_vec;

  // ****************************************************************
  // Masking and routing of the registered pending word
  // ****************************************************************
  // Gating uses the registered copies so both lines see one consistent snapshot
  assign normal_vec = state_reg.pending & state_reg.mask & ~state_reg.route;
  assign fast_vec = state_reg.pending & state_reg.mask & state_reg.route;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.pending = pending_new;
    state_next.mask = mask_new;
    state_next.route = route_new;
    state_next.status = status_new;
    // Line levels from the gated vectors
    state_next.normal_line = |normal_vec;
    state_next.fast_line = |fast_vec;
    state_next.event_line = |(state_reg.status & state_reg.mask);
    // Index vectors, higher channel numbers take priority
    state_next.normal_idx = ipm_top_index(normal_vec);
    state_next.fast_idx = ipm_top_index(fast_vec);
    // Read data stands for the single cycle after the strobe, zero otherwise
    state_next.rdata = UNMAPPED_READ;
    if (bus_rd) begin
      case (bus_addr)
        PENDING_WORD_ADDR: begin
          state_next.rdata = state_reg.pending;
        end
        MASK_WORD_ADDR: begin
          state_next.rdata = state_reg.mask;
        end
        ROUTE_SELECT_ADDR: begin
          state_next.rdata = state_reg.route;
        end
        EVENT_STATUS_ADDR: begin
          state_next.rdata = state_reg.status;
        end
        NORMAL_INDEX_ADDR: begin
          state_next.rdata = {{(DATA_W - IDX_W){1'b0}}, state_reg.normal_idx};
        end
        FAST_INDEX_ADDR: begin
          state_next.rdata = {{(DATA_W - IDX_W){1'b0}}, state_reg.fast_idx};
        end
        default: begin
          state_next.rdata = UNMAPPED_READ;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Pending is cleared only to give the flops a known start; software must not rely on it
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= '{
        pending: PENDING_RESET,
        mask: MASK_RESET,
        route: ROUTE_RESET,
        status: STATUS_RESET,
        rdata: UNMAPPED_READ,
        normal_idx: INDEX_NONE,
        fast_idx: INDEX_NONE,
        normal_line: 1'b0,
        fast_line: 1'b0,
        event_line: 1'b0
      };
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs, all from flops
  // ****************************************************************
  assign bus_rdata = state_reg.rdata;
  assign normal_irq = state_reg.normal_line;
  assign fast_irq = state_reg.fast_line;
  assign event_irq = state_reg.event_line;
  assign normal_line_index_vector = state_reg.normal_idx;
  assign fast_line_index_vector = state_reg.fast_idx;

endmodule : ipm_core

`default_nettype wire

// ---- core/ipm_sync.sv ----
// Two-flop synchroniser for interrupt request pins arriving from outside the clock domain
`timescale 1ns/100ps
`default_nettype none

module ipm_sync (
  input wire logic mclk, // System clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic [ipm_pkg::SYNC_W-1:0] pin_in, // Raw pin levels
  output logic [ipm_pkg::SYNC_W-1:0] pin_sync // Levels after two flops
);
  import ipm_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0] stage1;
    logic [SYNC_W-1:0] stage2;
  } ipm_sync_state_type;

  ipm_sync_state_type state_reg;
  ipm_sync_state_type state_next;

  // ****************************************************************
  // Next state: first stage feeds only the second stage
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.stage1 = pin_in;
    state_next.stage2 = state_reg.stage1;
  end

  // Registers take constants only under reset
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= '{stage1: SYNC_RESET, stage2: SYNC_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign pin_sync = state_reg.stage2;

endmodule : ipm_sync

`default_nettype wire

// ---- inc/ipm_pkg.sv ----
// Constants, types and helper functions shared by the interrupt pending and mask block
package ipm_pkg;

  // ****************************************************************
  // Bus widths
  // ****************************************************************
  localparam int ADDR_W = 36;
  localparam int DATA_W = 32;
  localparam int SRC_N = 32;
  localparam int IDX_W = 8;

  // ****************************************************************
  // Register byte addresses, top page of the address space
  // ****************************************************************
  localparam logic [ADDR_W-1:0] NORMAL_INDEX_ADDR = 36'hFFFFFFF20;
  localparam logic [ADDR_W-1:0] FAST_INDEX_ADDR = 36'hFFFFFFF24;
  localparam logic [ADDR_W-1:0] EVENT_STATUS_ADDR = 36'hFFFFFFF28;
  localparam logic [ADDR_W-1:0] ROUTE_SELECT_ADDR = 36'hFFFFFFF2C;
  localparam logic [ADDR_W-1:0] PENDING_WORD_ADDR = 36'hFFFFFFF30;
  localparam logic [ADDR_W-1:0] MASK_WORD_ADDR = 36'hFFFFFFF34;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [DATA_W-1:0] MASK_RESET = 32'h0;
  localparam logic [DATA_W-1:0] ROUTE_RESET = 32'h0;
  localparam logic [DATA_W-1:0] STATUS_RESET = 32'h0;
  localparam logic [DATA_W-1:0] PENDING_RESET = 32'h0;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0;
  localparam logic [IDX_W-1:0] INDEX_NONE = 8'h0;

  // ****************************************************************
  // Source bit positions in every 32-bit word
  // ****************************************************************
  localparam int BIT_EXT_FAULT = 31;
  localparam int BIT_SYS_SERIAL = 30;
  localparam int BIT_PWM0 = 29;
  localparam int BIT_PWM1 = 28;
  localparam int BIT_PWM2 = 27;
  localparam int BIT_PWM3 = 26;
  localparam int BIT_FAULT_MUX = 25;
  localparam int BIT_ADC = 24;
  localparam int BIT_CPOWER_RTC = 23;
  localparam int BIT_WCMP0 = 22;
  localparam int BIT_WCAP0 = 21;
  localparam int BIT_WCMP1 = 20;
  localparam int BIT_WCAP1_DT = 19;
  localparam int BIT_WOVF = 18;
  localparam int BIT_NT0 = 17;
  localparam int BIT_NT1 = 16;
  localparam int BIT_NT2 = 15;
  localparam int BIT_NT3 = 14;
  localparam int BIT_FE2 = 13;
  localparam int BIT_FE1 = 12;
  localparam int BIT_FE0 = 11;
  localparam int BIT_CMP_SERIAL = 10;
  localparam int BIT_PMBUS = 9;
  localparam int BIT_U1_TX = 8;
  localparam int BIT_U1_RX = 7;
  localparam int BIT_U0_TX = 6;
  localparam int BIT_U0_RX = 5;
  localparam int BIT_U_ERR = 4;
  localparam int BIT_WD_HALF = 3;
  localparam int BIT_WD_MAX = 2;
  localparam int BIT_EXT_PIN = 1;
  localparam int BIT_BROWNOUT = 0;

  // ****************************************************************
  // Pin synchroniser: external fault, external pin, brownout
  // ****************************************************************
  localparam int SYNC_W = 3;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 3'h0;

  // Highest set source wins; result is source number plus one, zero for none
  function automatic logic [IDX_W-1:0] ipm_top_index(input logic [SRC_N-1:0] vec);
    logic [IDX_W-1:0] idx;
    idx = INDEX_NONE;
    for (int i = 0; i < SRC_N; i++) begin
      if (vec[i]) begin
        idx = IDX_W'(i + 1);
      end
    end
    return idx;
  endfunction : ipm_top_index

endpackage : ipm_pkg

// ---- tb/ipm_core_properties.sv ----
// Checker of the interrupt pending and mask block, bound to its top module
`timescale 1ns/100ps
`default_nettype none

module ipm_core_properties (
  input wire logic mclk, // System clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic [ipm_pkg::ADDR_W-1:0] bus_addr, // Byte address
  input wire logic [ipm_pkg::DATA_W-1:0] bus_wdata, // Write data
  input wire logic bus_wr, // Write strobe
  input wire logic bus_rd, // Read strobe
  input wire logic [ipm_pkg::DATA_W-1:0] bus_rdata, // Read data
  input wire logic normal_irq, // Normal line
  input wire logic fast_irq, // Fast line
  input wire logic event_irq, // Sticky event line
  input wire logic [ipm_pkg::IDX_W-1:0] normal_line_index_vector, // Normal index
  input wire logic [ipm_pkg::IDX_W-1:0] fast_line_index_vector // Fast index
);
  import ipm_pkg::*;
  logic [DATA_W-1:0] mask_reg, mask_d1_reg, route_reg, route_d1_reg;
  logic [DATA_W-1:0] mask_win, froute_win, nroute_win;

  // ****************************************************************
  // Shadow words, with one cycle of history for the registered index
  // ****************************************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_reg <= 32'h0;
      mask_d1_reg <= 32'h0;
      route_reg <= 32'h0;
      route_d1_reg <= 32'h0;
    end else begin
      mask_d1_reg <= mask_reg;
      route_d1_reg <= route_reg;
      if (bus_wr && bus_addr == MASK_WORD_ADDR) mask_reg <= bus_wdata;
      if (bus_wr && bus_addr == ROUTE_SELECT_ADDR) route_reg <= bus_wdata;
    end
  end
  // The index was computed from the words as they stood one edge earlier
  assign mask_win = mask_d1_reg;
  assign froute_win = route_d1_reg;
  assign nroute_win = ~route_d1_reg;

  default clocking dc @(posedge mclk); endclocking
  default disable iff (sys_rst);

  rdata_idle_a: assert property (!bus_rd |=> bus_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  mask_readback_a: assert property (bus_rd && bus_addr == MASK_WORD_ADDR |=> bus_rdata == mask_reg)
    else $error("mask word read differs from last write");
  route_readback_a: assert property (bus_rd && bus_addr == ROUTE_SELECT_ADDR |=> bus_rdata == route_reg)
    else $error("route word read differs from last write");
  masked_quiet_a: assert property ((mask_reg == 32'h0) [*2] |=> !normal_irq && !fast_irq && !event_irq)
    else $error("interrupt line high with every source masked");
  fast_route_a: assert property ((route_reg == 32'h0) [*2] |=> !fast_irq && fast_line_index_vector == 8'h0)
    else $error("fast line used with no source routed to it");
  normal_flag_a: assert property (normal_irq == (normal_line_index_vector != 8'h0))
    else $error("normal line and normal index disagree");
  fast_flag_a: assert property (fast_irq == (fast_line_index_vector != 8'h0))
    else $error("fast line and fast index disagree");
  normal_index_a: assert property (normal_line_index_vector != 8'h0 |->
    mask_win[normal_line_index_vector - 8'h01] && nroute_win[normal_line_index_vector - 8'h01])
    else $error("normal index names a masked or fast source");
  fast_index_a: assert property (fast_line_index_vector != 8'h0 |->
    mask_win[fast_line_index_vector - 8'h01] && froute_win[fast_line_index_vector - 8'h01])
    else $error("fast index names a masked or normal source");
endmodule : ipm_core_properties

bind ipm_core ipm_core_properties chk_i (
  .mclk(mclk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .normal_irq(normal_irq),
  .fast_irq(fast_irq), .event_irq(event_irq), .normal_line_index_vector(normal_line_index_vector),
  .fast_line_index_vector(fast_line_index_vector)
);
`default_nettype wire

// ---- tb/ipm_src_model.sv ----
// Behavioural model of the peripheral request sources that feed the block
`timescale 1ns/100ps
`default_nettype none

module ipm_src_model (
  input wire logic mclk, // System clock
  input wire logic [31:0] want, // Request levels asked for by the bench
  output logic [31:0] rq // Request lines into the block
);
  initial rq = 32'h0;
  // On-chip sources move after a rising edge; pins move mid-cycle to stress the synchroniser
  always @(posedge mclk or negedge mclk) begin
    if (mclk) rq[30:2] <= want[30:2];
    else rq <= {want[31], rq[30:2], want[1:0]};
  end
endmodule : ipm_src_model
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking testbench of the interrupt pending and mask block
`timescale 1ns/100ps
`default_nettype none

module tb;
  import ipm_pkg::*;
  logic mclk = 1'h0;
  logic sys_rst = 1'h1;
  logic [ADDR_W-1:0] bus_addr = 36'h0;
  logic [DATA_W-1:0] bus_wdata = 32'h0;
  logic [DATA_W-1:0] bus_rdata;
  logic bus_wr = 1'h0;
  logic bus_rd = 1'h0;
  logic [31:0] want = 32'h0;
  logic [31:0] rq;
  logic normal_irq, fast_irq, event_irq;
  logic [IDX_W-1:0] nidx, fidx;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;

  // ****************************************************************
  // Clock, timeout and the parts under test
  // ****************************************************************
  initial forever #10 mclk = ~mclk;
  // About 520 cycles are needed; a hang beyond 4000 ends the run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      wrap_up();
    end
  end
  ipm_src_model src (.mclk(mclk), .want(want), .rq(rq));
  ipm_core dut (
    .mclk(mclk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .external_fault_request(rq[31]), .system_serial_request(rq[30]),
    .pwm_unit0_request(rq[29]), .pwm_unit1_request(rq[28]), .pwm_unit2_request(rq[27]),
    .pwm_unit3_request(rq[26]), .fault_mux_request(rq[25]), .adc_request(rq[24]),
    .constant_power_rtc_request(rq[23]), .wide_timer_compare0_request(rq[22]),
    .wide_timer_capture0_request(rq[21]), .wide_timer_compare1_request(rq[20]),
    .capture1_deadtime_request(rq[19]), .wide_timer_overflow_request(rq[18]), .narrow_timer0_request(rq[17]),
    .narrow_timer1_request(rq[16]), .narrow_timer2_request(rq[15]), .narrow_timer3_request(rq[14]),
    .front_end2_request(rq[13]), .front_end1_request(rq[12]), .front_end0_request(rq[11]),
    .comparator_serial_group_request(rq[10]), .pmbus_request(rq[9]), .uart1_tx_request(rq[8]),
    .uart1_rx_request(rq[7]), .uart0_tx_request(rq[6]), .uart0_rx_request(rq[5]), .uart_error_request(rq[4]),
    .watchdog_half_count_request(rq[3]), .watchdog_max_count_request(rq[2]), .external_pin_request(rq[1]),
    .brownout_request(rq[0]), .normal_irq(normal_irq), .fast_irq(fast_irq), .event_irq(event_irq),
    .normal_line_index_vector(nidx), .fast_line_index_vector(fidx)
  );

  // ****************************************************************
  // Bus and comparison tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_wr <= 1'h1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge mclk);
    bus_wr <= 1'h0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
    @(posedge mclk);
    bus_rd <= 1'h1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd <= 1'h0;
    #1 chk(what, exp, bus_rdata);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    idle(3);
    sys_rst <= 1'h0;
    rd(MASK_WORD_ADDR, 32'h0, "mask after reset");
    rd(ROUTE_SELECT_ADDR, 32'h0, "route after reset");
    rd(NORMAL_INDEX_ADDR, 32'h0, "normal index idle");
    $display("test reset done");
    // Writable mask, read-only pending word, silent unmapped place
    wr(MASK_WORD_ADDR, 32'hA5C3_0F96);
    rd(MASK_WORD_ADDR, 32'hA5C3_0F96, "mask readback");
    wr(PENDING_WORD_ADDR, 32'hFFFF_FFFF);
    rd(PENDING_WORD_ADDR, 32'h0, "pending after write");
    rd(36'h0_0000_0100, 32'h0, "unmapped read");
    $display("test access done");
    // Every source lands on its own bit and drives the normal line and index
    wr(MASK_WORD_ADDR, 32'hFFFF_FFFF);
    for (int i = 0; i < 32; i++) begin
      want <= 32'h1 << i;
      idle(6);
      rd(PENDING_WORD_ADDR, 32'h1 << i, "pending bit");
      chk("normal index", 32'(i + 1), {24'h0, nidx});
      chk("normal line", 32'h1, {31'h0, normal_irq});
      want <= 32'h0;
      idle(6);
    end
    $display("test mapping done");
    // Two sources at once: routing splits them onto the two lines, then masking quiets the fast one
    want <= 32'h0010_0020;
    wr(ROUTE_SELECT_ADDR, 32'h0010_0000);
    idle(6);
    #1 chk("fast index", 32'h15, {24'h0, fidx});
    chk("normal index", 32'h6, {24'h0, nidx});
    chk("fast line", 32'h1, {31'h0, fast_irq});
    rd(FAST_INDEX_ADDR, 32'h15, "fast index word");
    rd(ROUTE_SELECT_ADDR, 32'h0010_0000, "route readback");
    wr(MASK_WORD_ADDR, 32'h0000_0020);
    idle(4);
    #1 chk("fast line masked", 32'h0, {31'h0, fast_irq});
    rd(PENDING_WORD_ADDR, 32'h0010_0020, "pending while masked");
    $display("test routing done");
    // Sticky event: raised, masked, unmasked, cleared by writing one
    want <= 32'h0;
    wr(MASK_WORD_ADDR, 32'h0);
    wr(EVENT_STATUS_ADDR, 32'hFFFF_FFFF);
    want <= 32'h8000_0000;
    idle(3);
    want <= 32'h0;
    idle(6);
    rd(EVENT_STATUS_ADDR, 32'h8000_0000, "event status");
    chk("event masked", 32'h0, {31'h0, event_irq});
    wr(MASK_WORD_ADDR, 32'h8000_0000);
    idle(3);
    #1 chk("event raised", 32'h1, {31'h0, event_irq});
    wr(EVENT_STATUS_ADDR, 32'h8000_0000);
    idle(3);
    #1 chk("event cleared", 32'h0, {31'h0, event_irq});
    rd(EVENT_STATUS_ADDR, 32'h0, "event status cleared");
    $display("test event done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
